// ===== src/domc_deadtime_seq.sv
`default_nettype none
module domc_deadtime_seq
  import domc_pkg::*;
(
  input  wire logic pclk,           // System clock
  input  wire logic presetn,        // Async reset, active low
  input  wire logic run,            // Pair active in a PWM mode
  input  wire logic cmd,            // Effective on command
  input  wire logic prim_gate_high, // Sensed gate of commanded switch
  input  wire logic free_gate_high, // Sensed gate of freewheel switch
  output logic      prim_on,        // Commanded switch gate drive
  output logic      free_on         // Freewheel switch gate drive
);
  domc_seq_state_t  state;          // Sequencer state
  logic [CNT_W-1:0] cnt;            // Dead-time counter
  logic             watch_low;      // Watched gate is low

  // Off path watches the primary gate, on path the freewheel gate
  assign watch_low = (state == SEQ_ON_WAIT) ? !free_gate_high
                                            : !prim_gate_high;

  ////////////////////////////////////////////////////////////////////////////
  // State sequencing with dead time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_OFF_WAIT;
      cnt   <= '0;
    end else if (!run) begin
      // Idle parks in off wait, both switches off
      state <= SEQ_OFF_WAIT;
      cnt   <= '0;
    end else begin
      unique case (state)
        SEQ_OFF_WAIT: begin
          if (cmd) begin
            state <= SEQ_ON_WAIT;
            cnt   <= '0;
          end else if (!watch_low) begin
            cnt   <= '0;                     // Gate not low yet
          end else if (cnt == DEAD_LAST) begin
            state <= SEQ_FREE;
            cnt   <= '0;
          end else begin
            cnt   <= cnt + 1'b1;
          end
        end
        SEQ_FREE: begin
          if (cmd) begin
            state <= SEQ_ON_WAIT;            // Freewheel off first
          end
        end
        SEQ_ON_WAIT: begin
          if (!cmd) begin
            state <= SEQ_OFF_WAIT;
            cnt   <= '0;
          end else if (!watch_low) begin
            cnt   <= '0;
          end else if (cnt == DEAD_LAST) begin
            state <= SEQ_PRIM;
            cnt   <= '0;
          end else begin
            cnt   <= cnt + 1'b1;
          end
        end
        SEQ_PRIM: begin
          if (!cmd) begin
            state <= SEQ_OFF_WAIT;           // Primary off first
          end
        end
      endcase
    end
  end

  // Gate drives follow the state one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_on <= 1'b0;
      free_on <= 1'b0;
    end else begin
      prim_on <= run && (state == SEQ_PRIM) && cmd;
      free_on <= run && (state == SEQ_FREE) && !cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper counts of consecutive low gate cycles
  logic [CNT_W-1:0] prim_low_run;   // Primary gate low run length
  logic [CNT_W-1:0] free_low_run;   // Freewheel gate low run length

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_low_run <= '0;
      free_low_run <= '0;
    end else begin
      prim_low_run <= prim_gate_high ? '0 :
                      (&prim_low_run) ? prim_low_run : prim_low_run + 1'b1;
      free_low_run <= free_gate_high ? '0 :
                      (&free_low_run) ? free_low_run : free_low_run + 1'b1;
    end
  end

  a_no_overlap: assert property (
    @(posedge pclk) disable iff (!presetn) !(prim_on && free_on))
    else $error("Both switches of a pair driven together");

  a_on_dead_time: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(prim_on) |-> $past(free_low_run, 2) >= DEAD_LAST)
    else $error("Primary turned on before dead time elapsed");

  a_off_dead_time: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(free_on) |-> $past(prim_low_run, 2) >= DEAD_LAST)
    else $error("Freewheel turned on before dead time elapsed");

  a_off_prompt: assert property (
    @(posedge pclk) disable iff (!presetn)
    (prim_on && !cmd) |-> ##2 !prim_on)
    else $error("Primary not released after off command");
endmodule : domc_deadtime_seq
`default_nettype wire

// ===== src/domc_output_ctrl.sv
// Operation
// - Enable low forces every power stage off
// - Mode changes only apply while enable low
// - Channel on equals parallel line OR bit
// - Reset clears registers, forces stages off
// - Two-bit field selects modes one to four
// - Mode 1 lines drive paired stages, drains
// - Mode 2 low stages need PWM enable
// - Mode 2 high source freewheels for stage
// - Mode 2 on: source off, wait, stage
// - Mode 2 off: stage off, wait, source
// - Mode 3 sources need PWM enable bit
// - Mode 3 stage freewheels for high source
// - Mode 3 off: source off, wait, stage
// - Mode 4 lines drive stages; drivers serial
// - Mode 4 per-driver high/low at bit 8
//
// Decided for this implementation: the placing of the registers and register access over APB.
`default_nettype none
module domc_output_ctrl
  import domc_pkg::*;
(
  input  wire logic        pclk,                // 250 MHz clock
  input  wire logic        presetn,             // Reset pin, active low
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB access phase
  input  wire logic        pwrite,              // APB write
  input  wire logic [7:0]  paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic             pready,              // APB ready
  output logic [31:0]      prdata,              // APB read data
  output logic             pslverr,             // APB error
  input  wire logic        out_enable,          // Global enable pin
  input  wire logic [7:0]  parallel_pwm_line,   // Parallel drive lines
  input  wire logic [7:0]  stage_gate_high,     // Low stage gate sensed
  input  wire logic [3:0]  source_gate_high,    // Driver gate sensed
  output logic      [7:0]  low_side_stage,      // Low-side stage drives
  output logic      [3:0]  config_driver_drain, // Driver as low side
  output logic      [3:0]  config_driver_source // Driver as high side
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] cfg_mode;        // Written mode field
  logic [3:0] cfg_hs_sel;      // Per-driver high-side select
  logic [1:0] active_mode;     // Mode in force
  logic [7:0] ser_chan;        // Serial channel commands
  logic [3:0] ser_drv;         // Serial driver commands
  logic       pwm_en;          // PWM enable for pairs 1-4
  logic       access;          // APB access phase cycle
  logic       wr_take;         // Write committed this edge

  assign access  = psel && penable;
  assign wr_take = access && pready && pwrite;

  // One wait state: ready rises after the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
    end else begin
      pready  <= access && !pready;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
      if (access && !pready) begin
        unique case (paddr)
          REG_CONFIG: begin
            prdata[CFG_MODE_LSB +: 2]  <= cfg_mode;
            prdata[CFG_HSSEL_LSB +: 4] <= cfg_hs_sel;
          end
          REG_COMMAND: begin
            prdata[CMD_CHAN_LSB +: 8]  <= ser_chan;
            prdata[CMD_DRV_LSB +: 4]   <= ser_drv;
            prdata[CMD_PWMEN_BIT]      <= pwm_en;
          end
          REG_STATUS: begin
            prdata[ST_MODE_LSB +: 2]   <= active_mode;
            prdata[ST_STAGE_LSB +: 8]  <= low_side_stage;
            prdata[ST_DRAIN_LSB +: 4]  <= config_driver_drain;
            prdata[ST_SOURCE_LSB +: 4] <= config_driver_source;
            prdata[ST_ENABLE_BIT]      <= out_enable;
          end
          default: pslverr <= 1'b1;     // Unmapped address
        endcase
      end
    end
  end

  // Software-written fields, cleared by the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_mode   <= RST_MODE;
      cfg_hs_sel <= '0;
      ser_chan   <= '0;
      ser_drv    <= '0;
      pwm_en     <= 1'b0;
    end else if (wr_take) begin
      if (paddr == REG_CONFIG) begin
        cfg_mode   <= pwdata[CFG_MODE_LSB +: 2];
        cfg_hs_sel <= pwdata[CFG_HSSEL_LSB +: 4];
      end
      if (paddr == REG_COMMAND) begin
        ser_chan <= pwdata[CMD_CHAN_LSB +: 8];
        ser_drv  <= pwdata[CMD_DRV_LSB +: 4];
        pwm_en   <= pwdata[CMD_PWMEN_BIT];
      end
    end
  end

  // Written mode only takes hold while outputs are disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode <= RST_MODE;
    end else if (!out_enable) begin
      active_mode <= cfg_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commands and PWM pair sequencers
  logic [7:0] chan_cmd;        // Effective per-channel command
  logic       run2;            // Mode 2 pairs active
  logic       run3;            // Mode 3 pairs active
  logic [3:0] m2_stage_on;     // Mode 2 stage drives
  logic [3:0] m2_src_on;       // Mode 2 freewheel source drives
  logic [3:0] m3_src_on;       // Mode 3 source drives
  logic [3:0] m3_stage_on;     // Mode 3 freewheel stage drives

  assign chan_cmd = parallel_pwm_line | ser_chan;
  assign run2 = out_enable && pwm_en && active_mode == MODE_2;
  assign run3 = out_enable && pwm_en && active_mode == MODE_3;

  // Pair k couples channel k with the other side of index k^1
  for (genvar k = 0; k < 4; k++) begin : g_pair
    domc_deadtime_seq u_m2 (
      .pclk           (pclk),
      .presetn        (presetn),
      .run            (run2),
      .cmd            (chan_cmd[k]),
      .prim_gate_high (stage_gate_high[k]),
      .free_gate_high (source_gate_high[k ^ 1]),
      .prim_on        (m2_stage_on[k]),
      .free_on        (m2_src_on[k ^ 1])
    );
    domc_deadtime_seq u_m3 (
      .pclk           (pclk),
      .presetn        (presetn),
      .run            (run3),
      .cmd            (chan_cmd[k]),
      .prim_gate_high (source_gate_high[k]),
      .free_gate_high (stage_gate_high[k ^ 1]),
      .prim_on        (m3_src_on[k]),
      .free_on        (m3_stage_on[k ^ 1])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode mapping to power stages
  logic [7:0] next_stage;      // Next low-side stage drives
  logic [3:0] next_drain;      // Next driver low-side drives
  logic [3:0] next_source;     // Next driver high-side drives

  always_comb begin
    next_stage  = '0;
    next_drain  = '0;
    next_source = '0;
    unique case (active_mode)
      MODE_1: begin
        next_stage  = {chan_cmd[7:4], {2{chan_cmd[1]}},
                       {2{chan_cmd[0]}}};
        next_drain  = {{2{chan_cmd[3]}}, {2{chan_cmd[2]}}};
      end
      MODE_2: begin
        next_stage  = {chan_cmd[7:4], m2_stage_on};
        next_source = m2_src_on;
      end
      MODE_3: begin
        next_stage  = {chan_cmd[7:4], m3_stage_on};
        next_source = m3_src_on;
      end
      MODE_4: begin
        next_stage  = chan_cmd;
        next_drain  = ser_drv & ~cfg_hs_sel;
        next_source = ser_drv & cfg_hs_sel;
      end
    endcase
    // Enable low blocks all driving
    if (!out_enable) begin
      next_stage  = '0;
      next_drain  = '0;
      next_source = '0;
    end
  end

  // Registered gate drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_side_stage       <= '0;
      config_driver_drain  <= '0;
      config_driver_source <= '0;
    end else begin
      low_side_stage       <= next_stage;
      config_driver_drain  <= next_drain;
      config_driver_source <= next_source;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_enable_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !out_enable |=> (low_side_stage == '0 && config_driver_drain == '0
                     && config_driver_source == '0))
    else $error("Stage driven while enable low");

  a_mode_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_enable |=> $stable(active_mode))
    else $error("Mode changed while enable high");

  a_reset_clear: assert property (
    @(posedge pclk) $rose(presetn) |-> (low_side_stage == '0
      && active_mode == RST_MODE && ser_chan == '0))
    else $error("State not cleared by reset");

  a_mode4_or: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_4)
      |=> low_side_stage == $past(parallel_pwm_line | ser_chan))
    else $error("Mode 4 stage is not line OR serial bit");

  a_mode1_pairs: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_1 && chan_cmd[2])
      |=> config_driver_drain[1:0] == 2'h3)
    else $error("Mode 1 drains 1 and 2 not driven together");

  a_mode2_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active_mode == MODE_2 && !pwm_en)[*2] |=> low_side_stage[3:0] == '0)
    else $error("Mode 2 stage driven without PWM enable");

  a_mode3_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active_mode == MODE_3 && !pwm_en)[*2] |=> config_driver_source == '0)
    else $error("Mode 3 source driven without PWM enable");

  a_mode4_drv: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_4)
      |=> (config_driver_drain | config_driver_source) == $past(ser_drv))
    else $error("Mode 4 driver not following serial bits");

  a_reset_outs: assert property (
    @(posedge pclk) (!presetn)[*2] |-> (low_side_stage == '0
      && config_driver_drain == '0 && config_driver_source == '0))
    else $error("Stage driven while reset held");

  a_upper_direct: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_enable |=> low_side_stage[7:4] == $past(chan_cmd[7:4]))
    else $error("Stages 5 to 8 not following line OR serial bit");

  a_mode1_stage12: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_1 && chan_cmd[0])
      |=> low_side_stage[1:0] == 2'h3)
    else $error("Mode 1 stages 1 and 2 not driven together");

  a_mode1_stage34: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_1 && chan_cmd[1])
      |=> low_side_stage[3:2] == 2'h3)
    else $error("Mode 1 stages 3 and 4 not driven together");

  a_mode1_drain34: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_1 && chan_cmd[3])
      |=> config_driver_drain[3:2] == 2'h3)
    else $error("Mode 1 drains 3 and 4 not driven together");

  a_mode1_no_src: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active_mode == MODE_1) |=> config_driver_source == 4'h0)
    else $error("Source driven in mode 1");

  a_pwm_no_drain: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active_mode == MODE_2 || active_mode == MODE_3)
      |=> config_driver_drain == 4'h0)
    else $error("Drain driven in a PWM mode");

  // Cross-conduction guard: a pair must never conduct on both sides,
  // whichever of the two PWM modes owns it
  a_pair_cross: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active_mode == MODE_2 || active_mode == MODE_3)
      |-> (low_side_stage[3:0] & {config_driver_source[2],
           config_driver_source[3], config_driver_source[0],
           config_driver_source[1]}) == 4'h0)
    else $error("Stage and paired source driven together");

  a_drv_split: assert property (
    @(posedge pclk) disable iff (!presetn)
    (config_driver_drain & config_driver_source) == 4'h0)
    else $error("Driver used as both high and low side");

  a_mode4_side: assert property (
    @(posedge pclk) disable iff (!presetn)
    (out_enable && active_mode == MODE_4)
      |=> config_driver_source == $past(ser_drv & cfg_hs_sel))
    else $error("Mode 4 driver side not per select bit");
endmodule : domc_output_ctrl
`default_nettype wire

// ===== src/domc_pkg.sv
`default_nettype none
package domc_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CONFIG  = 8'h00;
  localparam logic [7:0] REG_COMMAND = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  // Config register fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_HSSEL_LSB = 8;
  // Command register fields
  localparam int CMD_CHAN_LSB  = 0;
  localparam int CMD_DRV_LSB   = 8;
  localparam int CMD_PWMEN_BIT = 16;
  // Status register fields
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_STAGE_LSB  = 8;
  localparam int ST_DRAIN_LSB  = 16;
  localparam int ST_SOURCE_LSB = 20;
  localparam int ST_ENABLE_BIT = 24;
  // Mode field encodings
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h1;
  localparam logic [1:0] MODE_3 = 2'h2;
  localparam logic [1:0] MODE_4 = 2'h3;
  // Reset values
  localparam logic [1:0]  RST_MODE    = 2'h0;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  // Dead time between complementary switches
  localparam int DEAD_NS      = 2000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEAD_CYC     = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W        = 10;
  localparam logic [CNT_W-1:0] DEAD_LAST = CNT_W'(DEAD_CYC - 1);
  // Pair sequencer states
  typedef enum logic [1:0] {
    SEQ_OFF_WAIT, SEQ_FREE, SEQ_ON_WAIT, SEQ_PRIM
  } domc_seq_state_t;
endpackage : domc_pkg
`default_nettype wire

// ===== tb/domc_gate_model.sv
`default_nettype none
module domc_gate_model (
  input  wire logic       pclk,   // System clock
  input  wire logic       slow,   // Long gate settle
  input  wire logic [7:0] stg,    // Stage gate drive
  input  wire logic [3:0] src,    // Driver gate drive
  output logic      [7:0] stg_hi, // Stage gate sensed
  output logic      [3:0] src_hi  // Driver gate sensed
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] tap [20]; // Gate charge history

  ////////////////////////////////////////////////////////////////////////
  // Gates follow their drive late, so dead time must wait on the sense
  always_ff @(posedge pclk) begin
    tap[0] <= {src, stg};
    for (int i = 1; i < 20; i++) begin
      tap[i] <= tap[i-1];
    end
  end
  // Slow gates settle near twenty cycles, prompt ones in three
  assign {src_hi, stg_hi} = slow ? tap[19] : tap[2];
endmodule : domc_gate_model
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench
  import domc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;               // Bus clock
  logic        presetn = 1'b0;            // Reset pin, active low
  logic        psel = 1'b0;               // APB select
  logic        penable = 1'b0;            // APB access
  logic        pwrite = 1'b0;             // APB direction
  logic [7:0]  paddr = 8'h00;             // APB address
  logic [31:0] pwdata = 32'h0;            // APB write data
  logic        pready;                    // APB ready
  logic [31:0] prdata;                    // APB read data
  logic        pslverr;                   // APB error
  logic        out_enable = 1'b0;         // Global enable pin
  logic [7:0]  parallel_pwm_line = 8'h00; // Parallel lines
  logic [7:0]  stage_gate_high;           // Stage gate sense
  logic [3:0]  source_gate_high;          // Driver gate sense
  logic [7:0]  low_side_stage;            // Stage drives
  logic [3:0]  config_driver_drain;       // Driver low side
  logic [3:0]  config_driver_source;      // Driver high side
  logic        slow = 1'b0;               // Slow gate select
  logic [1:0]  md = MODE_1;               // Expected active mode
  logic [33:0] notes [$];                 // Read, error, data notes
  logic [33:0] note;                      // Oldest note
  logic [31:0] rnd;                       // Random word
  logic [7:0]  e;                         // Effective commands
  logic [7:0]  s;                         // Expected stages
  logic [3:0]  d;                         // Expected drains
  int          bad_count = 0;             // Mismatches
  int          checks_done = 0;           // Comparisons
  int          seed = 33314;              // Random seed

  ////////////////////////////////////////////////////////////////////////
  always #2 pclk = ~pclk;

  domc_output_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .out_enable(out_enable), .parallel_pwm_line(parallel_pwm_line),
    .stage_gate_high(stage_gate_high),
    .source_gate_high(source_gate_high),
    .low_side_stage(low_side_stage),
    .config_driver_drain(config_driver_drain),
    .config_driver_source(config_driver_source));
  domc_gate_model gate_u (.pclk(pclk), .slow(slow), .stg(low_side_stage),
    .src(config_driver_source), .stg_hi(stage_gate_high),
    .src_hi(source_gate_high));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task close_out;
    $display("mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One transfer; the note carries expected error and read data
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat, input logic [32:0] x);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= dat;
    notes.push_back({~wr, x});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", 32'(pready), 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Watcher pairs every completed transfer with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      check("pslverr", 32'(pslverr), 32'(note[32]));
      if (note[33]) begin
        check("prdata", prdata, note[31:0]);
      end
    end
  end

  function automatic logic [31:0] stat(logic [7:0] st, logic [3:0] dr,
                                        logic [3:0] sr);
    return {7'h00, out_enable, sr, dr, st, 6'h00, md};
  endfunction : stat

  // Ports settle two edges after a change; status must agree
  task automatic outs(input logic [7:0] st, input logic [3:0] dr, sr);
    tick(2);
    check("stage", 32'(low_side_stage), 32'(st));
    check("drain", 32'(config_driver_drain), 32'(dr));
    check("source", 32'(config_driver_source), 32'(sr));
    apb(1'b0, REG_STATUS, 32'h0, {1'b0, stat(st, dr, sr)});
  endtask : outs

  // Mode and command written only with the enable pin held low
  task automatic set_mode(input logic [1:0] m, input logic [3:0] hs,
                          input logic [31:0] cmd);
    out_enable <= 1'b0;
    tick(2);
    check("off", 32'({low_side_stage, config_driver_drain,
          config_driver_source}), 32'h0);
    apb(1'b1, REG_CONFIG, 32'({hs, 6'h00, m}), 33'h0);
    apb(1'b1, REG_COMMAND, cmd, 33'h0);
    md = m;
    out_enable <= 1'b1;
  endtask : set_mode

  function automatic logic sense(input int k, input logic pr);
    if (md == MODE_2) begin
      return pr ? low_side_stage[k] : config_driver_source[k ^ 1];
    end
    return pr ? config_driver_source[k] : low_side_stage[k ^ 1];
  endfunction : sense

  task automatic wait_for(input int k, input logic pr, v, output int n);
    n = 0;
    while (sense(k, pr) !== v && n < 800) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_for

  // On then off of one pair; dead time counted after the gate sense
  task automatic pair_seq(input int k);
    int n;
    int lo;
    lo = DEAD_CYC + (slow ? 16 : 0);
    wait_for(k, 1'b0, 1'b1, n);
    check("free_on", 32'(n < 800), 32'h1);
    parallel_pwm_line <= 8'(1 << k);
    wait_for(k, 1'b0, 1'b0, n);
    check("free_off", 32'(n <= 4), 32'h1);
    wait_for(k, 1'b1, 1'b1, n);
    check("prim_on", 32'(n >= lo && n <= lo + 40), 32'h1);
    parallel_pwm_line <= 8'h00;
    wait_for(k, 1'b1, 1'b0, n);
    check("prim_off", 32'(n <= 4), 32'h1);
    wait_for(k, 1'b0, 1'b1, n);
    check("free_back", 32'(n >= lo && n <= lo + 40), 32'h1);
  endtask : pair_seq

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    check("rst", 32'({low_side_stage, config_driver_drain,
          config_driver_source}), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, REG_CONFIG, 32'h0, {1'b0, RST_WORD});
    apb(1'b0, REG_COMMAND, 32'h0, {1'b0, RST_WORD});
    apb(1'b0, 8'h0C, 32'h0, 33'h1_0000_0000);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, 33'h1_0000_0000);
    apb(1'b0, REG_CONFIG, 32'h0, 33'h0);
    out_enable <= 1'b1;
    repeat (4) begin
      rnd = $random(seed);
      apb(1'b1, REG_COMMAND, {24'h0, rnd[7:0]}, 33'h0);
      parallel_pwm_line <= rnd[15:8];
      e = rnd[15:8] | rnd[7:0];
      s = {e[7:4], e[1], e[1], e[0], e[0]};
      d = {e[3], e[3], e[2], e[2]};
      outs(s, d, 4'h0);
    end
    apb(1'b1, REG_CONFIG, 32'h3, 33'h0);
    outs(s, d, 4'h0);
    out_enable <= 1'b0;
    md = MODE_4;
    outs(8'h00, 4'h0, 4'h0);
    repeat (4) begin
      rnd = $random(seed);
      set_mode(MODE_4, rnd[19:16],
               32'({rnd[24], 4'h0, rnd[23:20], rnd[7:0]}));
      parallel_pwm_line <= rnd[15:8];
      outs(rnd[15:8] | rnd[7:0], rnd[23:20] & ~rnd[19:16],
           rnd[23:20] & rnd[19:16]);
    end
    for (int m = 1; m < 3; m++) begin
      parallel_pwm_line <= 8'hFF;
      set_mode(2'(m), 4'h0, 32'h0);
      outs(8'hF0, 4'h0, 4'h0);
      parallel_pwm_line <= 8'h00;
      set_mode(2'(m), 4'h0, 32'h0001_0000);
      for (int k = 0; k < 4; k++) begin
        slow <= (k == 3);
        tick(1);
        pair_seq(k);
      end
    end
    presetn <= 1'b0;
    @(negedge pclk);
    check("rst_mid", 32'({low_side_stage, config_driver_drain,
          config_driver_source}), 32'h0);
    tick(2);
    presetn <= 1'b1;
    apb(1'b0, REG_CONFIG, 32'h0, 33'h0);
    tick(1);
    check("pending", 32'(notes.size()), 32'h0);
    close_out();
  end

  // Hang guard, well past the expected run length
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
